// ---- rtl/asfe_defs.vh ----
// Register map, field positions, reset values and timing counts
`ifndef ASFE_DEFS_VH
`define ASFE_DEFS_VH

`define ASFE_OFS_CTRL     4'h0
`define ASFE_OFS_BUF      4'h4
`define ASFE_OFS_BAUD     4'h8

`define ASFE_CTL_RXDONE   0
`define ASFE_CTL_TXDONE   1
`define ASFE_CTL_RX9      2
`define ASFE_CTL_TX9      3
`define ASFE_CTL_RXEN     4
`define ASFE_CTL_MPF      5
`define ASFE_CTL_MODE_LO  6
`define ASFE_CTL_MODE_HI  7

`define ASFE_BAUD_DBL     0
`define ASFE_BAUD_X6      1
`define ASFE_BAUD_TSEL    2

`define ASFE_CTRL_RST     8'h00
`define ASFE_BAUD_RST     3'h0

`define ASFE_MODE0        2'h0
`define ASFE_MODE1        2'h1
`define ASFE_MODE2        2'h2

`define ASFE_MC_TOP12     4'hb
`define ASFE_MC_TOP6      4'h5
`define ASFE_M2_DIV       3'h4

`define ASFE_SAMP_A       4'h7
`define ASFE_SAMP_B       4'h8
`define ASFE_SAMP_C       4'h9
`define ASFE_ROLL         4'hf

`define ASFE_RX_PRELOAD   10'h3ff
`define ASFE_TX_ENDMARK   8'h01
`define ASFE_RX0_FIRST    4'h1
`define ASFE_RX0_LAST     4'h9

`define ASFE_RESP_OK      2'h0
`define ASFE_RESP_ERR     2'h2

`endif

// ---- rtl/asfe_top.v ----
// Asynchronous serial frame engine with AXI4-Lite register access
// Summary of operation
// - Mode 1 frame: zero start, eight data bits LSB first, one stop.
// - Mode 1 accepted frame stores its stop bit in rx_ninth_bit.
// - Mode 1 buffer write loads byte plus marker one, flags pending send.
// - Sending starts at the counter rollover after the buffer write.
// - Start bit first, data output a bit later, first shift a bit later.
// - Mode 1 shifts zeros in; marker beside MSB ends send, sets tx_done_flag.
// - Modes 2/3 load tx_ninth_bit; first shift inserts stop one, then zeros.
// - Modes 2/3 end when ninth bit is out; done at eleventh rollover.
// - Receiver hunts a falling edge sampled at sixteen times bit rate.
// - Start edge resets the counter and preloads the shift register with ones.
// - Each bit is the majority of samples at counter states 7, 8, 9.
// - A start bit that is not zero returns the receiver to hunting.
// - Bits enter the shift register; start at far end triggers final load.
// - Load only when rx_done_flag clear and filter off or qualifying bit one.
// - After the final shift the receiver hunts again, accepted or not.
// - Modes 2/3 frame has eleven bits; received ninth bit goes to rx_ninth_bit.
// - Mode 2 tick from oscillator division; mode 3 from timer overflow.
// - Mode 1 rate comes from one of two selectable timer overflows.
// - Shift mode receive samples pin per cycle, done on tenth cycle.
// - Modes 2/3 filter tests the received ninth bit, not the stop bit.
// - Async reception starts only while the receive enable bit is set.
// - baud_double selects the faster mode 2 divider.
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`include "asfe_defs.vh"

module asfe_top (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        port3_bit0_pin,
	input  wire        timer1_ovf,
	input  wire        timer2_ovf,
	output wire        txd_out
);

	localparam [2:0] RX_HUNT  = 3'h1;
	localparam [2:0] RX_BITS  = 3'h2;
	localparam [2:0] RX_SHIFT = 3'h4;
	localparam [2:0] TX_IDLE  = 3'h1;
	localparam [2:0] TX_START = 3'h2;
	localparam [2:0] TX_DATA  = 3'h4;
	localparam [7:0] CTRL_RST = `ASFE_CTRL_RST;

	function is_mapped;
		input [3:0] a;
		begin
			is_mapped = (a == `ASFE_OFS_CTRL) || (a == `ASFE_OFS_BUF) ||
				(a == `ASFE_OFS_BAUD);
		end
	endfunction

	function maj3;
		input a;
		input b;
		input c;
		begin
			maj3 = (a & b) | (a & c) | (b & c);
		end
	endfunction

	reg        aw_got_ff;
	reg        w_got_ff;
	reg [3:0]  awaddr_ff;
	reg [7:0]  wdata_ff;
	reg        wstrb0_ff;
	reg        bvalid_ff;
	reg [1:0]  bresp_ff;
	reg        rvalid_ff;
	reg [1:0]  rresp_ff;
	reg [31:0] rdata_ff;
	reg [1:0]  mode_ff;
	reg        mpf_ff;
	reg        rxen_ff;
	reg        tx9_ff;
	reg        rx9_ff;
	reg        txdone_ff;
	reg        rxdone_ff;
	reg        baud_double_ff;
	reg        x6_ff;
	reg        tsel_ff;
	reg [7:0]  rx_buf_ff;
	reg [3:0]  mc_cnt_ff;
	reg [1:0]  pre_ff;
	reg        half_ff;
	reg [3:0]  cnt_ff;
	reg        rx_meta_ff;
	reg        rx_sync_ff;
	reg        rx_prev_ff;
	reg [1:0]  samp_ff;
	reg [2:0]  rx_state_ff;
	reg [9:0]  rx_sr_ff;
	reg        rx_first_ff;
	reg [3:0]  rx0_cnt_ff;
	reg [2:0]  tx_state_ff;
	reg [8:0]  tx_sr_ff;
	reg        tx_req_ff;
	reg        tx_shifted_ff;
	reg        txd_ff;

	wire wr_fire = aw_got_ff && w_got_ff;
	wire wr_en   = wr_fire && wstrb0_ff && is_mapped(awaddr_ff);
	wire wr_ctrl = wr_en && (awaddr_ff == `ASFE_OFS_CTRL);
	wire wr_buf  = wr_en && (awaddr_ff == `ASFE_OFS_BUF);
	wire wr_baud = wr_en && (awaddr_ff == `ASFE_OFS_BAUD);

	assign s_axi_awready = !aw_got_ff && !bvalid_ff;
	assign s_axi_wready  = !w_got_ff && !bvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rresp   = rresp_ff;
	assign s_axi_rdata   = rdata_ff;
	assign txd_out       = txd_ff;

	wire [7:0] ctrl_val = {mode_ff, mpf_ff, rxen_ff, tx9_ff, rx9_ff,
		txdone_ff, rxdone_ff};

	// Address and data may arrive in either order
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_ff <= 1'b0;
			w_got_ff  <= 1'b0;
			awaddr_ff <= 4'h0;
			wdata_ff  <= 8'h00;
			wstrb0_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff  <= `ASFE_RESP_OK;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_ff  <= 1'b1;
				wdata_ff  <= s_axi_wdata[7:0];
				wstrb0_ff <= s_axi_wstrb[0];
			end
			if (wr_fire)
			begin
				aw_got_ff <= 1'b0;
				w_got_ff  <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff  <= is_mapped(awaddr_ff) ? `ASFE_RESP_OK : `ASFE_RESP_ERR;
			end
			else if (bvalid_ff && s_axi_bready)
				bvalid_ff <= 1'b0;
		end
	end

	// Reading the buffer has no side effect on the done flag
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_ff <= 1'b0;
			rresp_ff  <= `ASFE_RESP_OK;
			rdata_ff  <= 32'h0000_0000;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= is_mapped(s_axi_araddr) ? `ASFE_RESP_OK : `ASFE_RESP_ERR;
			case (s_axi_araddr)
				`ASFE_OFS_CTRL: rdata_ff <= {24'h000000, ctrl_val};
				`ASFE_OFS_BUF:  rdata_ff <= {24'h000000, rx_buf_ff};
				`ASFE_OFS_BAUD: rdata_ff <= {29'h00000000, tsel_ff, x6_ff,
					baud_double_ff};
				default:        rdata_ff <= 32'h0000_0000;
			endcase
		end
		else if (rvalid_ff && s_axi_rready)
			rvalid_ff <= 1'b0;
	end

	// Baud tick generation
	wire [3:0] mc_top  = x6_ff ? `ASFE_MC_TOP6 : `ASFE_MC_TOP12;
	wire       mc_tick = (mc_cnt_ff == mc_top);
	wire [1:0] m2_shift = {1'b0, baud_double_ff} + {1'b0, x6_ff};
	wire [2:0] m2_div   = `ASFE_M2_DIV >> m2_shift;
	wire [1:0] pre_top  = m2_div[1:0] - 2'h1;
	wire       ovf_sel  = tsel_ff ? timer2_ovf : timer1_ovf;
	// Doubled rate in 6-clock mode cannot exceed one tick per overflow
	wire       t_tick   = ovf_sel && (baud_double_ff || x6_ff || half_ff);
	// mode 2 fixed divider, modes 1/3 timer
	wire       tick     = (mode_ff == `ASFE_MODE2) ? (pre_ff == pre_top) : t_tick;
	wire       roll     = tick && (cnt_ff == `ASFE_ROLL);

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mc_cnt_ff <= 4'h0;
			pre_ff    <= 2'h0;
			half_ff   <= 1'b0;
		end
		else
		begin
			mc_cnt_ff <= mc_tick ? 4'h0 : mc_cnt_ff + 4'h1;
			pre_ff    <= (pre_ff == pre_top) ? 2'h0 : pre_ff + 2'h1;
			if (ovf_sel)
				half_ff <= !half_ff;
		end
	end

	// Receive side
	wire async_mode = (mode_ff != `ASFE_MODE0);
	// falling edge at the tick rate
	wire start_edge = (rx_state_ff == RX_HUNT) && async_mode && rxen_ff &&
		tick && rx_prev_ff && !rx_sync_ff;
	wire bit_val    = maj3(samp_ff[0], samp_ff[1], rx_sync_ff);
	wire bit_time   = (rx_state_ff == RX_BITS) && tick && (cnt_ff == `ASFE_SAMP_C);
	wire [9:0] rx_shifted = {bit_val, rx_sr_ff[9:1]};
	// start bit at the far end
	wire rx_final   = (mode_ff == `ASFE_MODE1) ? !rx_sr_ff[1] : !rx_sr_ff[0];
	// qualifying bit is stop in mode 1, ninth bit otherwise
	wire rx_ninth   = (mode_ff == `ASFE_MODE1) ? bit_val : rx_sr_ff[9];
	wire [7:0] rx_byte = (mode_ff == `ASFE_MODE1) ? rx_sr_ff[9:2] : rx_sr_ff[8:1];
	wire rx_accept  = bit_time && !rx_first_ff && rx_final && !rxdone_ff &&
		(!mpf_ff || rx_ninth);
	wire rx0_done   = (rx_state_ff == RX_SHIFT) && mc_tick &&
		(rx0_cnt_ff == `ASFE_RX0_LAST);

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rx_meta_ff <= 1'b1;
			rx_sync_ff <= 1'b1;
			rx_prev_ff <= 1'b1;
			samp_ff    <= 2'h3;
		end
		else
		begin
			rx_meta_ff <= port3_bit0_pin;
			rx_sync_ff <= rx_meta_ff;
			if (tick)
				rx_prev_ff <= rx_sync_ff;
			if (tick && (cnt_ff == `ASFE_SAMP_A))
				samp_ff[0] <= rx_sync_ff;
			if (tick && (cnt_ff == `ASFE_SAMP_B))
				samp_ff[1] <= rx_sync_ff;
		end
	end

	// shared counter; a start edge realigns it for both directions
	always @(posedge aclk)
	begin
		if (!aresetn)
			cnt_ff <= 4'h0;
		else if (start_edge)
			cnt_ff <= 4'h0;
		else if (tick)
			cnt_ff <= cnt_ff + 4'h1;
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rx_state_ff <= RX_HUNT;
			rx_sr_ff    <= `ASFE_RX_PRELOAD;
			rx_first_ff <= 1'b0;
			rx0_cnt_ff  <= 4'h0;
		end
		else
		begin
			case (rx_state_ff)
				RX_HUNT:
				begin
					if (start_edge)
					begin
						rx_sr_ff    <= `ASFE_RX_PRELOAD;
						rx_first_ff <= 1'b1;
						rx_state_ff <= RX_BITS;
					end
					// shift mode starts on enable with flag clear
					else if (!async_mode && rxen_ff && !rxdone_ff)
					begin
						rx0_cnt_ff  <= 4'h0;
						rx_state_ff <= RX_SHIFT;
					end
				end
				RX_BITS:
				begin
					if (!async_mode)
						rx_state_ff <= RX_HUNT;
					else if (bit_time)
					begin
						if (rx_first_ff && bit_val)
							rx_state_ff <= RX_HUNT;
						else if (!rx_first_ff && rx_final)
							rx_state_ff <= RX_HUNT;
						else
							rx_sr_ff <= rx_shifted;
						rx_first_ff <= 1'b0;
					end
				end
				RX_SHIFT:
				begin
					if (async_mode)
						rx_state_ff <= RX_HUNT;
					else if (mc_tick)
					begin
						rx0_cnt_ff <= rx0_cnt_ff + 4'h1;
						if (rx0_cnt_ff >= `ASFE_RX0_FIRST)
							rx_sr_ff <= {rx_sync_ff, rx_sr_ff[9:1]};
						if (rx0_done)
							rx_state_ff <= RX_HUNT;
					end
				end
				default:
					rx_state_ff <= RX_HUNT;
			endcase
		end
	end

	// Transmit side
	wire tx_end = (tx_state_ff == TX_DATA) && roll && tx_shifted_ff &&
		(tx_sr_ff[8:1] == `ASFE_TX_ENDMARK);

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tx_state_ff   <= TX_IDLE;
			tx_sr_ff      <= 9'h1ff;
			tx_req_ff     <= 1'b0;
			tx_shifted_ff <= 1'b0;
			txd_ff        <= 1'b1;
		end
		else
		begin
			// start low, data from shifter, idle and stop high
			case (tx_state_ff)
				TX_START: txd_ff <= 1'b0;
				TX_DATA:  txd_ff <= tx_sr_ff[0];
				default:  txd_ff <= 1'b1;
			endcase
			case (tx_state_ff)
				TX_IDLE:
				begin
					// Writes in shift mode are not sent
					if (wr_buf && !tx_req_ff && async_mode)
					begin
						tx_sr_ff  <= {(mode_ff == `ASFE_MODE1) ? 1'b1 : tx9_ff, wdata_ff};
						tx_req_ff <= 1'b1;
					end
					else if (tx_req_ff && roll)
					begin
						tx_req_ff     <= 1'b0;
						tx_shifted_ff <= 1'b0;
						tx_state_ff   <= TX_START;
					end
				end
				// data output one bit time after start
				TX_START:
					if (roll)
						tx_state_ff <= TX_DATA;
				TX_DATA:
				begin
					if (roll)
					begin
						// stop one on first shift in modes 2/3
						tx_sr_ff <= {mode_ff[1] && !tx_shifted_ff, tx_sr_ff[8:1]};
						tx_shifted_ff <= 1'b1;
						// last shift ends the send phase
						if (tx_end)
							tx_state_ff <= TX_IDLE;
					end
				end
				default:
					tx_state_ff <= TX_IDLE;
			endcase
		end
	end

	// Control and status; a hardware set wins over a software clear
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mode_ff        <= CTRL_RST[`ASFE_CTL_MODE_HI:`ASFE_CTL_MODE_LO];
			mpf_ff         <= 1'b0;
			rxen_ff        <= 1'b0;
			tx9_ff         <= 1'b0;
			rx9_ff         <= 1'b0;
			txdone_ff      <= 1'b0;
			rxdone_ff      <= 1'b0;
			baud_double_ff <= 1'b0;
			x6_ff          <= 1'b0;
			tsel_ff        <= 1'b0;
			rx_buf_ff      <= 8'h00;
		end
		else
		begin
			if (wr_ctrl)
			begin
				mode_ff <= wdata_ff[`ASFE_CTL_MODE_HI:`ASFE_CTL_MODE_LO];
				mpf_ff  <= wdata_ff[`ASFE_CTL_MPF];
				rxen_ff <= wdata_ff[`ASFE_CTL_RXEN];
				tx9_ff  <= wdata_ff[`ASFE_CTL_TX9];
			end
			if (wr_baud)
			begin
				baud_double_ff <= wdata_ff[`ASFE_BAUD_DBL];
				x6_ff          <= wdata_ff[`ASFE_BAUD_X6];
				tsel_ff        <= wdata_ff[`ASFE_BAUD_TSEL];
			end
			if (tx_end)
				txdone_ff <= 1'b1;
			else if (wr_ctrl)
				txdone_ff <= wdata_ff[`ASFE_CTL_TXDONE];
			// load buffer and ninth bit, set done flag
			if (rx_accept)
			begin
				rxdone_ff <= 1'b1;
				rx9_ff    <= rx_ninth;
				rx_buf_ff <= rx_byte;
			end
			else if (rx0_done)
			begin
				rxdone_ff <= 1'b1;
				rx_buf_ff <= rx_sr_ff[9:2];
			end
			else if (wr_ctrl)
			begin
				rxdone_ff <= wdata_ff[`ASFE_CTL_RXDONE];
				rx9_ff    <= wdata_ff[`ASFE_CTL_RX9];
			end
		end
	end

endmodule // asfe_top

// ---- dv/asfe_checker_assertions.sv ----
// Bus handshake and serial line timing assertions
module asfe_checker (
	input wire        aclk,
	input wire        aresetn,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire        txd_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       prev_ff;
	logic [7:0] run_ff;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Cycles since the line last changed
	always_ff @(posedge aclk)
	begin
		prev_ff <= txd_out;
		if (!aresetn || txd_out != prev_ff)
			run_ff <= 8'h00;
		else if (run_ff != 8'hff)
			run_ff <= run_ff + 8'h01;
	end
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence wr_answer;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence
	bresp_time_a: assert property (wr_taken |=> wr_answer)
		else $error("write response not on second edge");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	bresp_end_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response not retired");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	rresp_time_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	bit_len_a: assert property (txd_out != prev_ff |-> run_ff >= 8'h0f)
		else $error("serial bit shorter than sixteen ticks");
	line_idle_a: assert property ($rose(aresetn) |-> txd_out && s_axi_awready)
		else $error("line not idle high after reset");
endmodule // asfe_checker

bind asfe_top asfe_checker i_asfe_checker (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.txd_out(txd_out));

// ---- dv/asfe_remote.sv ----
// Remote serial station: sends frames and captures frames
module asfe_remote (
	input  wire  aclk,
	input  wire  txd_out,
	output logic rxd
);
	timeunit 1ns;
	timeprecision 1ns;
	initial rxd = 1'b1;
	// start zero, LSB first, stop one
	task automatic send(input logic [8:0] bits, input int n, input int bp, input logic glitch);
		int i;
		// short low pulse, not a start
		if (glitch)
		begin
			@(posedge aclk) rxd <= 1'b0;
			repeat (3) @(posedge aclk);
			rxd <= 1'b1;
			repeat (bp) @(posedge aclk);
		end
		for (i = 0; i < n; i++)
		begin
			@(posedge aclk) rxd <= (i == 0) ? 1'b0 : (i == n - 1) ? 1'b1 : bits[i - 1];
			repeat (bp - 1) @(posedge aclk);
		end
	endtask
	// Samples mid-bit; returns in the stop bit
	task automatic grab(input int n, input int bp, output logic [10:0] f);
		int i;
		f = 11'h000;
		@(negedge txd_out);
		repeat (bp / 2) @(posedge aclk);
		for (i = 0; i < n; i++)
		begin
			f[i] = txd_out;
			if (i < n - 1)
				repeat (bp) @(posedge aclk);
		end
	endtask
endmodule // asfe_remote

// ---- dv/test_async_serial_frame_engine.sv ----
`include "asfe_defs.vh"
// Self-checking bench for the serial frame engine
module test_async_serial_frame_engine;
	timeunit 1ns;
	timeprecision 1ns;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        port3_bit0_pin, timer1_ovf, timer2_ovf, txd_out;
	wire         awready, wready, bvalid, arready, rvalid;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	logic [3:0]  awaddr, araddr, wstrb;
	logic [31:0] wdata, rv;
	logic [1:0]  resp;
	logic [10:0] fr, e;
	logic [7:0]  b;
	logic [2:0]  m;
	logic [35:0] rxt [6] = '{{8'h80, 8'h11, 8'h00, 8'h80, 4'h4}, {8'h90, 8'h3c, 8'h3c, 8'h91, 4'h2},
		{8'h00, 8'h77, 8'h3c, 8'h91, 4'h4}, {8'hb0, 8'h5a, 8'h3c, 8'hb0, 4'h0},
		{8'h00, 8'h5a, 8'h5a, 8'hb5, 4'h4}, {8'h50, 8'h96, 8'h96, 8'h55, 4'h1}};
	int          n_mismatch = 0, num_checks = 0, cyc = 0, n, bp, t0, d;
	asfe_top i_asfe_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .port3_bit0_pin(port3_bit0_pin), .timer1_ovf(timer1_ovf),
		.timer2_ovf(timer2_ovf), .txd_out(txd_out));
	asfe_remote i_asfe_remote (.aclk(aclk), .txd_out(txd_out), .rxd(port3_bit0_pin));
	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	// Two unrelated overflow rates expose a wrong timer select
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		timer1_ovf <= (cyc % 3 == 0);
		timer2_ovf <= (cyc % 4 == 0);
		if (cyc == 20000)
		begin
			n_mismatch++;
			give_verdict;
		end
	end
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] dv);
		logic aw, w, bk;
		@(posedge aclk);
		awaddr <= a;
		wdata <= dv;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(negedge aclk);
			aw = awvalid && awready;
			w = wvalid && wready;
			bk = bvalid;
			resp = bresp;
			@(posedge aclk);
			if (aw)
				awvalid <= 1'b0;
			if (w)
				wvalid <= 1'b0;
		end while (bk !== 1'b1);
		bready <= 1'b0;
	endtask
	task rd(input logic [3:0] a);
		logic t, r;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(negedge aclk);
			t = arvalid && arready;
			r = rvalid;
			rv = rdata;
			resp = rresp;
			@(posedge aclk);
			if (t)
				arvalid <= 1'b0;
		end while (r !== 1'b1);
		rready <= 1'b0;
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = 0;
		wstrb = 4'hf;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`ASFE_OFS_CTRL);
		chk("ctrl reset", 32'h0, rv);
		wr(4'hc, 32'h1);
		chk("bresp unmapped", `ASFE_RESP_ERR, resp);
		rd(4'hc);
		chk("rresp unmapped", `ASFE_RESP_ERR, resp);
		// Baud: double rate, second timer
		wr(`ASFE_OFS_BAUD, 32'h5);
		rd(`ASFE_OFS_BAUD);
		chk("baud", 32'h5, rv);
		$display("test registers done");
		for (m = 3'h1; m < 3'h4; m++)
		begin
			b = {5'h14, m};
			n = (m == 3'h1) ? 10 : 11;
			bp = (m == 3'h2) ? 32 : 64;
			e = (m == 3'h1) ? {2'h1, b, 1'b0} : {1'b1, m[0], b, 1'b0};
			wr(`ASFE_OFS_CTRL, {24'h0, m[1:0], 2'h0, m[0], 3'h0});
			fork
				i_asfe_remote.grab(n, bp, fr);
				begin
					wr(`ASFE_OFS_BUF, {24'h0, b});
					t0 = cyc;
					do
						rd(`ASFE_OFS_CTRL);
					while (rv[1] !== 1'b1 && cyc - t0 < 2000);
					d = cyc - t0;
				end
			join
			chk("tx frame", {21'h0, e}, {21'h0, fr});
			chk("tx done time", 32'h1, {31'h0, d > (n - 1) * bp - 8 && d <= n * bp + 8});
		end
		$display("test transmit done");
		for (int i = 0; i < 6; i++)
		begin
			if (rxt[i][35:28] != 8'h00)
				wr(`ASFE_OFS_CTRL, {24'h0, rxt[i][35:28]});
			bp = rxt[i][0] ? 64 : 32;
			i_asfe_remote.send({rxt[i][2], rxt[i][27:20]}, rxt[i][0] ? 10 : 11, bp, rxt[i][1]);
			repeat (bp) @(posedge aclk);
			rd(`ASFE_OFS_BUF);
			chk("rx buffer", {24'h0, rxt[i][19:12]}, rv);
			rd(`ASFE_OFS_CTRL);
			chk("rx ctrl", {24'h0, rxt[i][11:4]}, rv);
		end
		$display("test receive done");
		// Shift mode receive, line idle high, 6-clock machine cycle of 6 aclk
		wr(`ASFE_OFS_BAUD, 32'h2);
		wr(`ASFE_OFS_CTRL, 32'h10);
		t0 = cyc;
		do
			rd(`ASFE_OFS_CTRL);
		while (rv[0] !== 1'b1 && cyc - t0 < 2000);
		d = cyc - t0;
		chk("rx0 done time", 32'h1, {31'h0, d > 9 * 6 - 8 && d <= 10 * 6 + 12});
		chk("rx0 ctrl", 32'h11, rv);
		rd(`ASFE_OFS_BUF);
		chk("rx0 buffer", 32'hff, rv);
		$display("test shift receive done");
		give_verdict;
	end
endmodule // test_async_serial_frame_engine
